/* tpm_consts.svh */
// Constants for the timer pair mode and clock select block
// Assumes inclusion by bare name from every design file that needs them
`ifndef TPM_CONSTS_SVH
`define TPM_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets (low 12 address bits)
// ----------------------------------------------------------------------
`define TPM_OFF_CMP_B    12'h108
`define TPM_OFF_MODE_B   12'h10c
`define TPM_OFF_CMP_C    12'h110
`define TPM_OFF_MODE_C   12'h114
`define TPM_OFF_CMP_D    12'h118
`define TPM_OFF_MODE_D   12'h11c
`define TPM_OFF_RUN      12'h120
`define TPM_OFF_STATUS   12'h124
`define TPM_OFF_MASK     12'h128

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define TPM_MODE_RESET   8'h00
`define TPM_CMP_RESET    16'h0000
`define TPM_EVT_RESET    6'h00
`define TPM_FLD_OPMODE   7:6
`define TPM_FLD_PERIOD   5:4
`define TPM_FLD_UPSEL    3:2
`define TPM_FLD_LOSEL    1:0
`define TPM_HSIZE_WORD   3'b010

// ----------------------------------------------------------------------
// Prescaler tap widths: taps fire every 2, 8, 32 and 512 cycles
// ----------------------------------------------------------------------
`define TPM_TAP_ONE_BITS  1
`define TPM_TAP_FOUR_BITS 3
`define TPM_TAP_16_BITS   5
`define TPM_TAP_256_BITS  9

`endif

/* tpm_pkg.sv */
// Types shared by the timer pair mode and clock select block
// Assumes nothing beyond a SystemVerilog compiler
package tpm_pkg;

    typedef enum logic [1:0] {
        TPM_DUAL    = 2'b00,
        TPM_CASCADE = 2'b01,
        TPM_PPG     = 2'b10,
        TPM_PWM     = 2'b11
    } tpm_mode_t;

    typedef enum logic [1:0] {
        TPM_SEL_ZERO = 2'b00,
        TPM_SEL_ONE  = 2'b01,
        TPM_SEL_TWO  = 2'b10,
        TPM_SEL_TRI  = 2'b11
    } tpm_sel_t;

endpackage

/* tpm_prescaler.sv */
// Free-running prescaler giving four single-cycle tap pulses
// Assumes one clock domain and asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "tpm_consts.svh"

module tpm_prescaler (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      prescaler_tap_one,
    output logic      prescaler_tap_four,
    output logic      prescaler_tap_sixteen,
    output logic      prescaler_tap_256
);
    import tpm_pkg::*;

    logic [8:0] count;
    logic [3:0] tap;
    wire  [3:0] next_tap;

    // ------------------------------------------------------------------
    // Tap decode
    // ------------------------------------------------------------------
    genvar i;
    for (i = 0; i < 4; i++) begin : g_tap
        localparam int W = (i == 0) ? `TPM_TAP_ONE_BITS :
                           (i == 1) ? `TPM_TAP_FOUR_BITS :
                           (i == 2) ? `TPM_TAP_16_BITS : `TPM_TAP_256_BITS;
        assign next_tap[i] = &count[W-1:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 9'h000;
            tap   <= 4'h0;
        end else begin
            count <= count + 9'h001;
            tap   <= next_tap;
        end
    end

    assign prescaler_tap_one     = tap[0];
    assign prescaler_tap_four    = tap[1];
    assign prescaler_tap_sixteen = tap[2];
    assign prescaler_tap_256     = tap[3];

endmodule
`default_nettype wire

/* tpm_clock_select.sv */
// Count clock selection for the lower and upper timer of one pair
// Assumes tap, pin and match inputs are single-cycle tick pulses
`timescale 1ns/1ps
`default_nettype none

module tpm_clock_select #(
    parameter bit HAS_PIN = 1'b0
) (
    input  wire tpm_pkg::tpm_mode_t pair_mode,
    input  wire tpm_pkg::tpm_sel_t  lower_sel,
    input  wire tpm_pkg::tpm_sel_t  upper_sel,
    input  wire logic               prescaler_tap_one,
    input  wire logic               prescaler_tap_four,
    input  wire logic               prescaler_tap_sixteen,
    input  wire logic               prescaler_tap_256,
    input  wire logic               pin_tick,
    input  wire logic               lower_match,
    input  wire logic               lower_overflow,
    output logic                    lower_tick,
    output logic                    upper_tick
);
    import tpm_pkg::*;

    // ------------------------------------------------------------------
    // Lower timer source
    // ------------------------------------------------------------------
    always_comb begin
        unique case (lower_sel)
            // Pairs without a count pin never tick on code 00
            TPM_SEL_ZERO: lower_tick = HAS_PIN ? pin_tick : 1'b0;
            TPM_SEL_ONE:  lower_tick = prescaler_tap_one;
            TPM_SEL_TWO:  lower_tick = prescaler_tap_four;
            TPM_SEL_TRI:  lower_tick = prescaler_tap_sixteen;
        endcase
    end

    // ------------------------------------------------------------------
    // Upper timer source, same for every pair
    // ------------------------------------------------------------------
    always_comb begin
        if (pair_mode == TPM_CASCADE) begin
            upper_tick = lower_overflow;
        end else begin
            unique case (upper_sel)
                TPM_SEL_ZERO: upper_tick = lower_match;
                TPM_SEL_ONE:  upper_tick = prescaler_tap_one;
                TPM_SEL_TWO:  upper_tick = prescaler_tap_sixteen;
                TPM_SEL_TRI:  upper_tick = prescaler_tap_256;
            endcase
        end
    end

endmodule
`default_nettype wire

/* tpm_top.sv */
// Three cascadable 8-bit timer pairs with mode and clock selection
// Assumes a single AHB-Lite master; count pin is synchronous to hclk
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tpm_consts.svh"

module tpm_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        lower_c_count_input_pin,
    output logic             irq,
    output logic [2:0]       pair_wave,
    output logic [5:0]       timer_match
);
    import tpm_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0]  timer_pair_b_mode;
    logic [7:0]  timer_pair_c_mode;
    logic [7:0]  timer_pair_d_mode;
    logic [15:0] pair_b_compare;
    logic [15:0] pair_c_compare;
    logic [15:0] pair_d_compare;
    logic [5:0]  run_ctrl;
    logic [5:0]  event_status;
    logic [5:0]  event_mask;
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic        pin_q;

    wire         tap_one;
    wire         tap_four;
    wire         tap_sixteen;
    wire         tap_256;
    wire  [5:0]  event_vec;
    wire  [2:0]  wave_vec;
    logic [7:0]  pair_mode [0:2];
    logic [15:0] pair_cmp  [0:2];

    assign pair_mode[0] = timer_pair_b_mode;
    assign pair_mode[1] = timer_pair_c_mode;
    assign pair_mode[2] = timer_pair_d_mode;
    assign pair_cmp[0]  = pair_b_compare;
    assign pair_cmp[1]  = pair_c_compare;
    assign pair_cmp[2]  = pair_d_compare;

    // ------------------------------------------------------------------
    // AHB-Lite decode
    // ------------------------------------------------------------------
    // Zero-wait slave: reads are looked up in the address phase, writes
    // land at the end of the data phase. A read right behind a write to
    // the same register therefore still returns the old value.
    wire        addr_phase = hsel && hready && htrans[1];
    wire        rd_take    = addr_phase && !hwrite;
    wire        wr_take    = addr_phase && hwrite && (hsize == `TPM_HSIZE_WORD);
    wire [11:0] rd_addr    = haddr[11:0];
    wire        rd_status  = rd_take && (rd_addr == `TPM_OFF_STATUS);

    wire wr_mode_b = wr_pend && (wr_addr == `TPM_OFF_MODE_B);
    wire wr_mode_c = wr_pend && (wr_addr == `TPM_OFF_MODE_C);
    wire wr_mode_d = wr_pend && (wr_addr == `TPM_OFF_MODE_D);
    wire wr_cmp_b  = wr_pend && (wr_addr == `TPM_OFF_CMP_B);
    wire wr_cmp_c  = wr_pend && (wr_addr == `TPM_OFF_CMP_C);
    wire wr_cmp_d  = wr_pend && (wr_addr == `TPM_OFF_CMP_D);
    wire wr_run    = wr_pend && (wr_addr == `TPM_OFF_RUN);
    wire wr_mask   = wr_pend && (wr_addr == `TPM_OFF_MASK);

    wire [31:0] rd_data =
        (rd_addr == `TPM_OFF_MODE_B) ? {24'h000000, timer_pair_b_mode} :
        (rd_addr == `TPM_OFF_MODE_C) ? {24'h000000, timer_pair_c_mode} :
        (rd_addr == `TPM_OFF_MODE_D) ? {24'h000000, timer_pair_d_mode} :
        (rd_addr == `TPM_OFF_CMP_B)  ? {16'h0000, pair_b_compare} :
        (rd_addr == `TPM_OFF_CMP_C)  ? {16'h0000, pair_c_compare} :
        (rd_addr == `TPM_OFF_CMP_D)  ? {16'h0000, pair_d_compare} :
        (rd_addr == `TPM_OFF_RUN)    ? {26'h0000000, run_ctrl} :
        (rd_addr == `TPM_OFF_STATUS) ? {26'h0000000, event_status} :
        (rd_addr == `TPM_OFF_MASK)   ? {26'h0000000, event_mask} :
                                       32'h00000000;

    // Hardware set wins over the read-clear in the same cycle
    wire [5:0] next_status = (event_status & ~(rd_status ? 6'h3f : 6'h00)) | event_vec;

    // ------------------------------------------------------------------
    // Bus response
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
            wr_pend   <= 1'b0;
            wr_addr   <= 12'h000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= rd_take ? rd_data : 32'h00000000;
            wr_pend   <= wr_take;
            wr_addr   <= rd_addr;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_pair_b_mode <= `TPM_MODE_RESET;
            timer_pair_c_mode <= `TPM_MODE_RESET;
            timer_pair_d_mode <= `TPM_MODE_RESET;
            pair_b_compare    <= `TPM_CMP_RESET;
            pair_c_compare    <= `TPM_CMP_RESET;
            pair_d_compare    <= `TPM_CMP_RESET;
            run_ctrl          <= `TPM_EVT_RESET;
            event_mask        <= `TPM_EVT_RESET;
        end else begin
            if (wr_mode_b) timer_pair_b_mode <= hwdata[7:0];
            if (wr_mode_c) timer_pair_c_mode <= hwdata[7:0];
            if (wr_mode_d) timer_pair_d_mode <= hwdata[7:0];
            if (wr_cmp_b)  pair_b_compare    <= hwdata[15:0];
            if (wr_cmp_c)  pair_c_compare    <= hwdata[15:0];
            if (wr_cmp_d)  pair_d_compare    <= hwdata[15:0];
            if (wr_run)    run_ctrl          <= hwdata[5:0];
            if (wr_mask)   event_mask        <= hwdata[5:0];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_status <= `TPM_EVT_RESET;
            irq          <= 1'b0;
            timer_match  <= `TPM_EVT_RESET;
            pin_q        <= 1'b0;
        end else begin
            event_status <= next_status;
            irq          <= |(event_status & event_mask);
            timer_match  <= event_vec;
            pin_q        <= lower_c_count_input_pin;
        end
    end

    assign pair_wave = wave_vec;

    // Pin counts on its rising edge; pin is already synchronous
    wire pin_edge = lower_c_count_input_pin && !pin_q;

    tpm_prescaler u_prescaler (
        .hclk                  (hclk),
        .hresetn               (hresetn),
        .prescaler_tap_one     (tap_one),
        .prescaler_tap_four    (tap_four),
        .prescaler_tap_sixteen (tap_sixteen),
        .prescaler_tap_256     (tap_256)
    );

    // ------------------------------------------------------------------
    // Sequences shared by the pair checks
    // ------------------------------------------------------------------
    sequence s_count_step(logic en, logic tick, logic hit);
        en && tick && hit;
    endsequence

    sequence s_cleared(logic [7:0] cnt);
        cnt == 8'h00;
    endsequence

    // ------------------------------------------------------------------
    // Timer pairs
    // ------------------------------------------------------------------
    genvar g;
    for (g = 0; g < 3; g++) begin : g_pair
        tpm_mode_t  pmode;
        tpm_sel_t   lsel;
        tpm_sel_t   usel;
        logic [7:0] lo_cnt;
        logic [7:0] up_cnt;
        logic       wave;
        wire        lo_tick;
        wire        up_tick;

        assign pmode = tpm_mode_t'(pair_mode[g][`TPM_FLD_OPMODE]);
        assign lsel  = tpm_sel_t'(pair_mode[g][`TPM_FLD_LOSEL]);
        assign usel  = tpm_sel_t'(pair_mode[g][`TPM_FLD_UPSEL]);

        wire [1:0]  period  = pair_mode[g][`TPM_FLD_PERIOD];
        wire [7:0]  cmp_lo  = pair_cmp[g][7:0];
        wire [7:0]  cmp_hi  = pair_cmp[g][15:8];
        wire        run_lo  = run_ctrl[2*g];
        wire        run_up  = run_ctrl[2*g+1];
        wire [7:0]  lo_inc  = lo_cnt + 8'h01;
        wire [7:0]  up_inc  = up_cnt + 8'h01;
        wire        lo_hit  = (lo_inc == cmp_lo);
        wire        up_hit  = (up_inc == cmp_hi);
        wire        lo_ovf  = run_lo && lo_tick && (lo_cnt == 8'hff);
        // Reserved period code runs as the full 8-bit cycle
        wire [7:0]  pmask   = (period == 2'b01) ? 8'h3f :
                              (period == 2'b10) ? 8'h7f : 8'hff;
        wire        pwm_end = ((lo_cnt | ~pmask) == 8'hff);
        wire [15:0] c16_inc = {up_cnt, lo_cnt} + 16'h0001;
        wire        hit16   = (c16_inc == pair_cmp[g]);
        wire        is_dual = (pmode == TPM_DUAL);
        wire        is_cas  = (pmode == TPM_CASCADE);
        wire        is_ppg  = (pmode == TPM_PPG);
        wire        is_pwm  = (pmode == TPM_PWM);
        wire        lo_step = run_lo && lo_tick;
        wire        up_step = run_up && up_tick;
        wire        m16     = is_cas && lo_step && hit16;
        wire        ppg_end = is_ppg && lo_step && (lo_inc == cmp_hi);
        wire        lo_ev   = !is_cas && lo_step && lo_hit;
        wire        up_ev   = is_cas ? m16 : (!is_ppg && up_step && up_hit);

        wire [7:0] next_lo =
            !run_lo                                 ? 8'h00 :
            !lo_tick                                ? lo_cnt :
            (is_dual && lo_hit)                     ? 8'h00 :
            m16                                     ? 8'h00 :
            ppg_end                                 ? 8'h00 :
            (is_pwm && pwm_end)                     ? 8'h00 :
                                                      lo_inc;
        wire [7:0] next_up =
            (!run_up || is_ppg || m16)              ? 8'h00 :
            !up_step                                ? up_cnt :
            (!is_cas && up_hit)                     ? 8'h00 :
                                                      up_inc;
        wire next_wave =
            (is_pwm && lo_step && pwm_end)          ? 1'b1 :
            (is_pwm && lo_ev)                       ? 1'b0 :
            (is_ppg && lo_ev)                       ? 1'b1 :
            ppg_end                                 ? 1'b0 :
            ((is_dual || is_cas) && (lo_ev || m16)) ? !wave :
                                                      wave;

        tpm_clock_select #(
            .HAS_PIN (g == 1)
        ) u_clock_select (
            .pair_mode             (pmode),
            .lower_sel             (lsel),
            .upper_sel             (usel),
            .prescaler_tap_one     (tap_one),
            .prescaler_tap_four    (tap_four),
            .prescaler_tap_sixteen (tap_sixteen),
            .prescaler_tap_256     (tap_256),
            .pin_tick              (pin_edge),
            .lower_match           (lo_ev),
            .lower_overflow        (lo_ovf),
            .lower_tick            (lo_tick),
            .upper_tick            (up_tick)
        );

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                lo_cnt <= 8'h00;
                up_cnt <= 8'h00;
                wave   <= 1'b0;
            end else begin
                lo_cnt <= next_lo;
                up_cnt <= next_up;
                wave   <= next_wave;
            end
        end

        assign event_vec[2*g]   = lo_ev;
        assign event_vec[2*g+1] = up_ev;
        assign wave_vec[g]      = wave;

        AST_CASCADE_UPPER_CLK: assert property (@(posedge hclk) disable iff (!hresetn)
            is_cas |-> (up_tick == lo_ovf))
            else $error("cascade upper clock is not lower overflow");
        AST_UPPER_MATCH_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
            (!is_cas && usel == TPM_SEL_ZERO) |-> (up_tick == lo_ev))
            else $error("upper code 00 does not follow lower match");
        AST_UPPER_TAP_256: assert property (@(posedge hclk) disable iff (!hresetn)
            (!is_cas && usel == TPM_SEL_TRI) |-> (up_tick == tap_256))
            else $error("upper code 11 does not follow tap 256");
        AST_LOWER_TAP_FOUR: assert property (@(posedge hclk) disable iff (!hresetn)
            (lsel == TPM_SEL_TWO) |-> (lo_tick == tap_four))
            else $error("lower code 10 does not follow tap four");
        if (g == 1) begin : g_pin_chk
            AST_PIN_SELECT: assert property (@(posedge hclk) disable iff (!hresetn)
                (lsel == TPM_SEL_ZERO) |-> (lo_tick == pin_edge))
                else $error("pin code does not follow count pin");
        end else begin : g_nopin_chk
            AST_NO_PIN_TICK: assert property (@(posedge hclk) disable iff (!hresetn)
                (lsel == TPM_SEL_ZERO) |-> !lo_tick)
                else $error("pin-less lower timer ticked on code 00");
        end
        AST_MATCH_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
            (s_count_step(is_dual && run_lo, lo_tick, lo_hit))
            |=> s_cleared(lo_cnt) ##0 event_status[2*g] ##0 timer_match[2*g])
            else $error("lower match did not clear and flag");
        AST_PWM_PERIOD_64: assert property (@(posedge hclk) disable iff (!hresetn)
            (s_count_step(is_pwm && run_lo && period == 2'b01, lo_tick, lo_cnt[5:0] == 6'h3f))
            |=> s_cleared(lo_cnt) ##0 wave)
            else $error("PWM 64 cycle did not wrap");
        AST_PPG_CYCLE: assert property (@(posedge hclk) disable iff (!hresetn)
            (s_count_step(is_ppg && run_lo, lo_tick, lo_inc == cmp_hi && lo_inc != cmp_lo))
            |=> s_cleared(lo_cnt) ##0 !wave)
            else $error("pattern cycle did not end on upper compare");
    end

    AST_MODE_RESET: assert property (@(posedge hclk)
        $rose(hresetn) |-> (timer_pair_b_mode == 8'h00 && timer_pair_c_mode == 8'h00
                            && timer_pair_d_mode == 8'h00))
        else $error("mode registers not zero after reset");
    AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        (|(event_status & event_mask)) |=> irq)
        else $error("interrupt not raised for unmasked status");

endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for tpm_top: registers, clock selects, modes, interrupt
// Assumes tpm_top answers with zero waits and runs on the single hclk domain
`timescale 1ns/1ps
`default_nettype none
`include "tpm_consts.svh"

module tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        pin = 1'b0;
    logic        pin_en = 1'b0;
    logic        pin_div = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    wire         hreadyout;
    wire         hresp;
    wire         irq;
    wire  [31:0] hrdata;
    wire  [2:0]  pair_wave;
    wire  [5:0]  timer_match;
    wire  [8:0]  obs = {pair_wave, timer_match};
    int          miscompares = 0;
    int          checks = 0;

    always #4 hclk = ~hclk;
    // Pin rises every fourth cycle, slower than tap one, so a wrong pick shows
    always @(posedge hclk) begin
        if (pin_en) begin
            pin_div <= ~pin_div;
            if (pin_div) pin <= ~pin;
        end
    end

    tpm_top u_tpm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .lower_c_count_input_pin(pin), .irq(irq), .pair_wave(pair_wave),
        .timer_match(timer_match));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; read data lands in rdata
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        hsize <= `TPM_HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask

    // Stopping first clears the counters, so every setup starts from zero
    task automatic go(input int g, input logic [7:0] m, input logic [15:0] cp,
                      input logic [5:0] run);
        bus(1'b1, `TPM_OFF_RUN, 32'h0);
        bus(1'b1, `TPM_OFF_CMP_B + 12'(8 * g), {16'h0, cp});
        bus(1'b1, `TPM_OFF_MODE_B + 12'(8 * g), {24'h0, m});
        bus(1'b1, `TPM_OFF_RUN, {26'h0, run});
    endtask

    // First rise may end a partial period, so the second to third is timed
    task automatic per(input int i, input int exp);
        logic p;
        int   r;
        int   n;
        int   c;
        p = obs[i];
        r = 0;
        n = 0;
        c = 0;
        while (r < 3 && n < 8000) begin
            @(posedge hclk);
            n++;
            if (obs[i] === 1'b1 && p !== 1'b1) begin
                r++;
                if (r == 2) c = n;
            end
            p = obs[i];
        end
        chk(32'(n - c), 32'(exp));
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        for (int g = 0; g < 3; g++) begin
            bus(1'b0, `TPM_OFF_MODE_B + 12'(8 * g), 32'h0);
            chk(rdata, 32'h0);
            bus(1'b1, `TPM_OFF_MODE_B + 12'(8 * g), 32'h59 + 32'(g));
            bus(1'b0, `TPM_OFF_MODE_B + 12'(8 * g), 32'h0);
            chk(rdata, 32'h59 + 32'(g));
        end
        bus(1'b0, 12'h200, 32'h0);
        chk(rdata, 32'h0);
        chk(32'(hresp), 32'h0);
    endtask

    task automatic t_taps;
        for (int g = 0; g < 3; g++) begin
            for (int c = 1; c < 4; c++) begin
                go(g, 8'(c), 16'h0004, 6'(1 << (2 * g)));
                per(2 * g, 4 * (c == 1 ? 2 : (c == 2 ? 8 : 32)));
            end
        end
        pin_en <= 1'b1;
        go(1, 8'h00, 16'h0004, 6'h04);
        per(2, 16);
        per(7, 32);
        pin_en <= 1'b0;
    endtask

    task automatic t_upper;
        int exp [4] = '{16, 4, 64, 1024};
        for (int c = 0; c < 4; c++) begin
            go(2, {4'h0, 2'(c), 2'b01}, 16'h0204, 6'h30);
            per(5, exp[c]);
        end
        // Upper code 11 is ignored: it counts lower overflows instead
        go(0, 8'h4d, 16'h0101, 6'h03);
        per(1, 514);
    endtask

    task automatic t_pwm;
        for (int c = 1; c < 4; c++) begin
            go(0, {2'b11, 2'(c), 4'b0001}, 16'h0004, 6'h01);
            per(6, 2 << (5 + c));
        end
        // Pattern period is set by the upper compare, not the lower one
        go(2, 8'h81, 16'h0a04, 6'h10);
        per(8, 20);
    endtask

    task automatic t_irq;
        bus(1'b1, `TPM_OFF_RUN, 32'h0);
        bus(1'b0, `TPM_OFF_STATUS, 32'h0);
        bus(1'b1, `TPM_OFF_MASK, 32'h1);
        go(0, 8'h01, 16'h0004, 6'h01);
        repeat (20) @(posedge hclk);
        chk(32'(irq), 32'h1);
        bus(1'b1, `TPM_OFF_RUN, 32'h0);
        bus(1'b0, `TPM_OFF_STATUS, 32'h0);
        chk(rdata & 32'h1, 32'h1);
        repeat (3) @(posedge hclk);
        chk(32'(irq), 32'h0);
        bus(1'b1, `TPM_OFF_MASK, 32'h0);
        bus(1'b1, `TPM_OFF_RUN, 32'h1);
        repeat (20) @(posedge hclk);
        chk(32'(irq), 32'h0);
    endtask

    task automatic test_done;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_regs;
        t_taps;
        t_upper;
        t_pwm;
        t_irq;
        test_done;
    end

    // About five times the expected run length
    initial begin
        #400000;
        miscompares++;
        test_done;
    end
endmodule

`default_nettype wire
